// ==== design/perf_counter_event_select.sv ====
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module perf_counter_event_select
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources from the core, on pclk.
	input wire logic [1:0] completed_count,
	input wire logic [1:0] dispatched_count,
	input wire logic [31:0] timebase_lower,
	input wire logic l1_icache_miss,
	input wire logic instr_translation_buffer_miss,
	input wire logic l2_instr_miss,
	input wire logic branch_not_taken,
	input wire logic problem_state_bit,
	input wire logic reserved_load_done,
	input wire logic [1:0] load_store_count,
	input wire logic snoop_seen,
	input wire logic l1_castout,
	input wire logic system_unit_done,
	input wire logic ifetch_l1_miss,
	input wire logic branch_spec_correct,
	// Live counter value.
	output logic [31:0] counter_value
);

	// ****************************************************************
	// Helper functions.
	// ****************************************************************

	// Maps a time-base selector value to its bit in the lower word.
	// Bits are numbered from the top of the 64-bit time base.
	function automatic int tb_pos(input int code);
		int pos;
		pos = perf_counter_pkg::TB_BIT63_POS;
		case (code)
			0: pos = perf_counter_pkg::TB_BIT47_POS;
			1: pos = perf_counter_pkg::TB_BIT51_POS;
			2: pos = perf_counter_pkg::TB_BIT55_POS;
			default: pos = perf_counter_pkg::TB_BIT63_POS;
		endcase
		return pos;
	endfunction : tb_pos

	// Tells whether an address is one of the mapped registers.
	function automatic logic addr_mapped(input logic [11:0] addr);
		logic hit;
		hit = (addr == perf_counter_pkg::MONITOR_CONTROL_ZERO_ADDR) ||
			(addr == perf_counter_pkg::PERF_COUNTER_TWO_ADDR) ||
			(addr == perf_counter_pkg::EVENT_STATUS_ADDR);
		return hit;
	endfunction : addr_mapped

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	// Control register and counter state.
	logic [5:0] sel_ff;
	logic [1:0] tb_sel_ff;
	logic [31:0] count_ff;
	logic [31:0] nxt_count;
	logic [1:0] inc;

	// Register bus state and decoded strobes.
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic access;
	logic wr_commit;
	logic wr_ctl;
	logic wr_cnt;
	logic [31:0] ctl_word;

	// Event counts and pulses, one register stage behind the core.
	logic [1:0] completed_ff;
	logic [1:0] dispatched_ff;
	logic [1:0] load_store_ff;
	logic [11:0] pulse_ff;
	logic [31:0] status_word;

	// Edge history of the time-base bits and the privilege bit.
	logic [3:0] tb_bits;
	logic [3:0] tb_bits_ff;
	logic [3:0] tb_prev_ff;
	logic [3:0] tb_rise;
	logic pr_ff;
	logic pr_prev_ff;

	// ****************************************************************
	// APB slave.
	// ****************************************************************

	// An access is answered one cycle after its access phase begins.
	// The answer never waits on the event logic, so every transfer
	// has the same length.
	assign access = psel && penable && !pready_ff;

	// A write takes effect at the edge where pready is seen high.
	assign wr_commit = psel && penable && pready_ff && pwrite;

	// Each writable register is decoded once from the commit strobe.
	assign wr_ctl = wr_commit &&
		paddr == perf_counter_pkg::MONITOR_CONTROL_ZERO_ADDR;
	assign wr_cnt = wr_commit &&
		paddr == perf_counter_pkg::PERF_COUNTER_TWO_ADDR;

	// The ready strobe is a single-cycle pulse per transfer.
	// While it stands, the same access is not answered a second time.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_ff <= 1'b0;
		else
			pready_ff <= access;
	end

	// Unmapped addresses end with an error and change nothing.
	// Reads of them return zero.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_ff <= 1'b0;
		else
			pslverr_ff <= access && !addr_mapped(paddr);
	end

	// Status word shows the sampled event lines and time-base bits.
	// It is read-only: a write to it ends normally and changes nothing.
	assign status_word = {10'h000, pr_ff, tb_bits_ff, load_store_ff,
		dispatched_ff, completed_ff, pulse_ff[10:0]};

	// Control word as read back; bits outside the two fields read zero.
	always_comb
	begin
		ctl_word = 32'h00000000;
		ctl_word[perf_counter_pkg::SEL_LSB +: perf_counter_pkg::SEL_W] =
			sel_ff;
		ctl_word[perf_counter_pkg::TB_SEL_LSB +: perf_counter_pkg::TB_SEL_W] =
			tb_sel_ff;
	end

	// Read data is captured with the ready pulse and held after it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h00000000;
		else if (access && !pwrite)
		begin
			case (paddr)
				perf_counter_pkg::MONITOR_CONTROL_ZERO_ADDR:
					prdata_ff <= ctl_word;
				perf_counter_pkg::PERF_COUNTER_TWO_ADDR:
					prdata_ff <= count_ff;
				perf_counter_pkg::EVENT_STATUS_ADDR:
					prdata_ff <= status_word;
				default:
					prdata_ff <= 32'h00000000;
			endcase
		end
	end

	// The control register holds the event and time-base selectors.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sel_ff <= perf_counter_pkg::SEL_RESET;
			tb_sel_ff <= perf_counter_pkg::TB_SEL_RESET;
		end
		else if (wr_ctl)
		begin
			sel_ff <= pwdata[perf_counter_pkg::SEL_LSB +:
				perf_counter_pkg::SEL_W];
			tb_sel_ff <= pwdata[perf_counter_pkg::TB_SEL_LSB +:
				perf_counter_pkg::TB_SEL_W];
		end
	end

	// ****************************************************************
	// Event sampling.
	// ****************************************************************

	// Counted events are registered once to keep the adder path short.
	// The two end bits of the pulse word stay zero so that each event
	// lands at its own place in the status word.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			completed_ff <= 2'h0;
			dispatched_ff <= 2'h0;
			load_store_ff <= 2'h0;
			pulse_ff <= 12'h000;
		end
		else
		begin
			completed_ff <= completed_count;
			dispatched_ff <= dispatched_count;
			load_store_ff <= load_store_count;
			pulse_ff <= {1'b0, branch_spec_correct, ifetch_l1_miss,
				system_unit_done, l1_castout, snoop_seen,
				reserved_load_done, branch_not_taken, l2_instr_miss,
				instr_translation_buffer_miss, l1_icache_miss, 1'b0};
		end
	end

	// Each of the four candidate time-base bits is picked out here.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_tb
			assign tb_bits[gi] = timebase_lower[tb_pos(gi)];
		end
	endgenerate

	// All four candidates keep a history, so a selector change mid-run
	// never invents an edge from a different bit.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tb_bits_ff <= 4'h0;
			tb_prev_ff <= 4'h0;
		end
		else
		begin
			tb_bits_ff <= tb_bits;
			tb_prev_ff <= tb_bits_ff;
		end
	end

	// Only zero-to-one changes count.
	assign tb_rise = tb_bits_ff & ~tb_prev_ff;

	// Privilege bit history for change detection.
	// Both directions of change count, unlike the time-base edges.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pr_ff <= 1'b0;
			pr_prev_ff <= 1'b0;
		end
		else
		begin
			pr_ff <= problem_state_bit;
			pr_prev_ff <= pr_ff;
		end
	end

	// ****************************************************************
	// Event select and counter.
	// ****************************************************************

	// The select code picks the amount added this cycle. Every source
	// is read from its register stage, so a pulse seen at one edge is
	// added at the next, and so is a time-base or privilege change seen
	// at that edge. Codes above the last defined one add nothing, which
	// leaves the count where software put it.
	always_comb
	begin
		inc = 2'h0;
		case (sel_ff)
			perf_counter_pkg::SEL_HOLD:
				inc = 2'h0;
			perf_counter_pkg::SEL_CYCLES:
				inc = 2'h1;
			perf_counter_pkg::SEL_COMPLETED:
				inc = completed_ff;
			perf_counter_pkg::SEL_TB_EDGE:
				inc = {1'b0, tb_rise[tb_sel_ff]};
			perf_counter_pkg::SEL_DISPATCHED:
				inc = dispatched_ff;
			perf_counter_pkg::SEL_L1_IMISS:
				inc = {1'b0, pulse_ff[1]};
			perf_counter_pkg::SEL_ITB_MISS:
				inc = {1'b0, pulse_ff[2]};
			perf_counter_pkg::SEL_L2_IMISS:
				inc = {1'b0, pulse_ff[3]};
			perf_counter_pkg::SEL_BR_NOT_TAKEN:
				inc = {1'b0, pulse_ff[4]};
			perf_counter_pkg::SEL_PR_TOGGLE:
				inc = {1'b0, pr_ff ^ pr_prev_ff};
			perf_counter_pkg::SEL_RESERVED_LOAD:
				inc = {1'b0, pulse_ff[5]};
			perf_counter_pkg::SEL_LOAD_STORE:
				inc = load_store_ff;
			perf_counter_pkg::SEL_SNOOP:
				inc = {1'b0, pulse_ff[6]};
			perf_counter_pkg::SEL_CASTOUT:
				inc = {1'b0, pulse_ff[7]};
			perf_counter_pkg::SEL_SYSTEM_UNIT:
				inc = {1'b0, pulse_ff[8]};
			perf_counter_pkg::SEL_IFETCH_MISS:
				inc = {1'b0, pulse_ff[9]};
			perf_counter_pkg::SEL_BR_SPEC_OK:
				inc = {1'b0, pulse_ff[10]};
			default:
				inc = 2'h0;
		endcase
	end

	// A software write replaces the count; otherwise the event adds in.
	// The increment is at most three, so it is zero-extended to 32 bits.
	always_comb
	begin
		if (wr_cnt)
			nxt_count = pwdata;
		else
			nxt_count = count_ff + {30'h0, inc};
	end

	// The counter wraps silently at its top and raises no flag. A
	// software write at the same edge as an event wins, and that
	// cycle's increment is dropped.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_ff <= perf_counter_pkg::COUNTER_RESET;
		else
			count_ff <= nxt_count;
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************

	// Every output is a flip-flop, so nothing the core does reaches
	// the bus in the same cycle.
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign counter_value = count_ff;

endmodule : perf_counter_event_select

// ==== design/perf_counter_pkg.sv ====
package perf_counter_pkg;

	// ****************************************************************
	// Register map.
	// ****************************************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] MONITOR_CONTROL_ZERO_ADDR = 12'h000;
	localparam logic [11:0] PERF_COUNTER_TWO_ADDR = 12'h004;
	localparam logic [11:0] EVENT_STATUS_ADDR = 12'h008;

	// ****************************************************************
	// Field positions and reset values.
	// ****************************************************************
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 6;
	localparam int TB_SEL_LSB = 8;
	localparam int TB_SEL_W = 2;
	localparam logic [5:0] SEL_RESET = 6'h00;
	localparam logic [1:0] TB_SEL_RESET = 2'h0;
	localparam logic [31:0] COUNTER_RESET = 32'h00000000;

	// Positions in the lower time-base word of bits 47, 51, 55 and 63.
	localparam int TB_BIT47_POS = 16;
	localparam int TB_BIT51_POS = 12;
	localparam int TB_BIT55_POS = 8;
	localparam int TB_BIT63_POS = 0;

	// ****************************************************************
	// Event select codes.
	// ****************************************************************
	typedef enum logic [5:0] {
		SEL_HOLD = 6'h00,
		SEL_CYCLES = 6'h01,
		SEL_COMPLETED = 6'h02,
		SEL_TB_EDGE = 6'h03,
		SEL_DISPATCHED = 6'h04,
		SEL_L1_IMISS = 6'h05,
		SEL_ITB_MISS = 6'h06,
		SEL_L2_IMISS = 6'h07,
		SEL_BR_NOT_TAKEN = 6'h08,
		SEL_PR_TOGGLE = 6'h09,
		SEL_RESERVED_LOAD = 6'h0A,
		SEL_LOAD_STORE = 6'h0B,
		SEL_SNOOP = 6'h0C,
		SEL_CASTOUT = 6'h0D,
		SEL_SYSTEM_UNIT = 6'h0E,
		SEL_IFETCH_MISS = 6'h0F,
		SEL_BR_SPEC_OK = 6'h10
	} event_sel_t;

endpackage : perf_counter_pkg

// ==== testbench/perf_counter_asserts.sv ====
`timescale 1ns/1ps
// ********
// Port checker.
// ********
module perf_counter_asserts
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Counter.
	input wire logic [31:0] counter_value
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [5:0] sel_ff;
	logic [1:0] ts_ff;
	logic [1:0] age_ff;
	wire done = psel && penable && pready;
	wire wr_ctl = done && pwrite && paddr == 12'h000;
	wire wr_cnt = done && pwrite && paddr == 12'h004;
	wire quiet = age_ff == 2'h3 && !wr_cnt;
	// Counts edges, up to three, since the control register was last written.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			age_ff <= 2'h0;
		else if (wr_ctl)
			age_ff <= 2'h0;
		else if (age_ff != 2'h3)
			age_ff <= age_ff + 2'h1;
	// Mirrors the control register.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{ts_ff, sel_ff} <= 8'h00;
		else if (wr_ctl)
			{ts_ff, sel_ff} <= {pwdata[9:8], pwdata[5:0]};
	sequence access_first;
		psel && penable && !pready;
	endsequence
	AST_READY_LATE: assert property (access_first |=> pready)
		else $error("pready not in second access cycle");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_HOLD: assert property (quiet && sel_ff == 6'h00 |=>
		$stable(counter_value)) else $error("counter moved on hold");
	AST_CYCLE: assert property (quiet && sel_ff == 6'h01 |=>
		counter_value == $past(counter_value) + 32'h1)
		else $error("counter missed a cycle");
	AST_RESERVED: assert property (quiet && sel_ff > 6'h10 |=>
		$stable(counter_value)) else $error("reserved code counted");
	AST_STEP: assert property (!wr_cnt |=>
		counter_value - $past(counter_value) <= 32'h2)
		else $error("counter step above two");
	AST_CNT_WRITE: assert property (wr_cnt |=>
		counter_value == $past(pwdata)) else $error("counter write lost");
	AST_CTL_READ: assert property (done && !pwrite &&
		paddr == 12'h000 |-> prdata == {22'h0, ts_ff, 2'h0, sel_ff})
		else $error("bad control read");
	AST_UNMAPPED: assert property (done && paddr > 12'h008 |->
		pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
endmodule : perf_counter_asserts

// ==== testbench/core_event_model.sv ====
`timescale 1ns/1ps
// ********
// Core event sources, random while run is high.
// ********
module core_event_model
(
	// Clock and control.
	input wire logic pclk,
	input wire logic run,
	// Events.
	output logic [1:0] completed_count,
	output logic [1:0] dispatched_count,
	output logic [1:0] load_store_count,
	output logic [31:0] timebase_lower,
	output logic problem_state_bit,
	output logic [9:0] pulses
);
	logic [5:0] cnt_ff = 6'h00;
	logic [9:0] pulse_ff = 10'h000;
	logic [31:0] tb_ff = 32'h00000000;
	logic pr_ff = 1'b0;
	assign {completed_count, dispatched_count, load_store_count} = cnt_ff;
	assign pulses = pulse_ff;
	assign timebase_lower = tb_ff;
	assign problem_state_bit = pr_ff;
	// Counts stay within 0..2; levels hold while idle.
	always @(posedge pclk)
	begin
		cnt_ff <= run ? {2'($urandom_range(2)), 2'($urandom_range(2)),
			2'($urandom_range(2))} : 6'h00;
		pulse_ff <= run ? 10'($urandom) : 10'h000;
		tb_ff <= run ? $urandom : tb_ff;
		pr_ff <= run ? 1'($urandom) : pr_ff;
	end
endmodule : core_event_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`define C(n, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			$display("wrong value %s exp %h got %h", n, e, g); \
			err_count++; \
		end \
	end
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic run = 1'b0;
	wire logic [31:0] prdata, cv, timebase_lower;
	wire logic [1:0] completed_count, dispatched_count, load_store_count;
	wire logic [9:0] pv;
	wire logic pready, pslverr, problem_state_bit;
	int err_count = 0;
	int compares = 0;
	logic [31:0] acc = 32'h0, tb_q = 32'h0, rd, init, a0, e;
	logic pr_q = 1'b0, err;
	logic [5:0] cur_sel = 6'h00, s;
	logic [1:0] cur_ts = 2'h0, ts;
	perf_counter_event_select dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .completed_count,
		.dispatched_count, .timebase_lower, .l1_icache_miss(pv[0]),
		.instr_translation_buffer_miss(pv[1]), .l2_instr_miss(pv[2]),
		.branch_not_taken(pv[3]), .problem_state_bit,
		.reserved_load_done(pv[4]), .load_store_count, .snoop_seen(pv[5]),
		.l1_castout(pv[6]), .system_unit_done(pv[7]),
		.ifetch_l1_miss(pv[8]), .branch_spec_correct(pv[9]),
		.counter_value(cv));
	core_event_model model (.pclk, .run, .completed_count, .dispatched_count,
		.load_store_count, .timebase_lower, .problem_state_bit, .pulses(pv));
	// Increment expected from this cycle's events.
	function automatic logic [1:0] ev_inc(input logic [5:0] c,
		input logic [1:0] t);
		logic [4:0] p;
		case (t)
			2'h0: p = 5'(perf_counter_pkg::TB_BIT47_POS);
			2'h1: p = 5'(perf_counter_pkg::TB_BIT51_POS);
			2'h2: p = 5'(perf_counter_pkg::TB_BIT55_POS);
			default: p = 5'(perf_counter_pkg::TB_BIT63_POS);
		endcase
		case (c)
			6'h02: ev_inc = completed_count;
			6'h03: ev_inc = {1'b0, timebase_lower[p] & ~tb_q[p]};
			6'h04: ev_inc = dispatched_count;
			6'h09: ev_inc = {1'b0, problem_state_bit ^ pr_q};
			6'h0B: ev_inc = load_store_count;
			6'h05, 6'h06, 6'h07, 6'h08: ev_inc = {1'b0, pv[c - 6'h05]};
			6'h0A: ev_inc = {1'b0, pv[4]};
			6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10: ev_inc = {1'b0, pv[c - 6'h07]};
			default: ev_inc = 2'h0;
		endcase
	endfunction : ev_inc
	// One APB transfer, waiting for pready.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Prints the verdict and ends the run.
	task results;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	// Clock.
	initial
		forever #5 pclk = ~pclk;
	// Expected count accumulator.
	always @(posedge pclk)
	begin
		acc <= acc + 32'(ev_inc(cur_sel, cur_ts));
		tb_q <= timebase_lower;
		pr_q <= problem_state_bit;
	end
	// Watchdog.
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_count++;
		results();
	end
	// Main sequence: every select code, reserved codes, all bit selects.
	initial
	begin
		void'($urandom(80192));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		`C("ctl", 32'h0, rd);
		apb(1'b0, 12'h00C, 32'h0);
		`C("err", 33'h100000000, {err, rd});
		for (int k = 0; k < 23; k++)
		begin
			s = k < 17 ? 6'(k) : k == 17 ? 6'h11 : k == 18 ? 6'h3F : 6'h03;
			ts = k > 18 ? 2'(k - 19) : 2'($urandom);
			apb(1'b1, 12'h000, {22'h0, ts, 2'h0, s});
			cur_sel = s;
			cur_ts = ts;
			apb(1'b0, 12'h000, 32'h0);
			`C("ctl", {22'h0, ts, 2'h0, s}, rd);
			init = $urandom;
			apb(1'b1, 12'h004, init);
			a0 = acc;
			run <= 1'b1;
			repeat (24) @(posedge pclk);
			run <= 1'b0;
			repeat (5) @(posedge pclk);
			#1;
			if (s == 6'h01)
			begin
				e = cv + 32'hA;
				repeat (10) @(posedge pclk);
				#1;
				`C("cyc", e, cv);
			end
			else
			begin
				e = init + acc - a0;
				apb(1'b0, 12'h004, 32'h0);
				`C("c", e, rd);
				`C("v", e, cv);
			end
		end
		apb(1'b0, 12'h008, 32'h0);
		e = {10'h000, problem_state_bit,
			timebase_lower[perf_counter_pkg::TB_BIT63_POS],
			timebase_lower[perf_counter_pkg::TB_BIT55_POS],
			timebase_lower[perf_counter_pkg::TB_BIT51_POS],
			timebase_lower[perf_counter_pkg::TB_BIT47_POS], 17'h00000};
		`C("status", e, rd);
		results();
	end
endmodule : tb
bind perf_counter_event_select perf_counter_asserts chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.counter_value);
